// ===== rtl/isc_hyst.sv
`timescale 1ns/1ps
module isc_hyst #(
   parameter int DATA_W = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic update,
   input wire logic [DATA_W-1:0] value,
   input wire logic [DATA_W-1:0] high,
   input wire logic [DATA_W-1:0] low,
   input wire logic wake_enable,
   output logic comp_flag,
   output logic wake_n
);

   wire above = value > high;
   wire below = value < low;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         comp_flag <= 1'b0;
         wake_n <= 1'b1;
      end else begin
         if (update && below) begin
            comp_flag <= 1'b1;
         end else if (update && above) begin
            comp_flag <= 1'b0;
         end
         if (!wake_enable) begin
            wake_n <= 1'b1;
         end else if (update && above) begin
            wake_n <= 1'b0;
         end
      end
   end

endmodule : isc_hyst

// ===== rtl/isc_pacer.sv
`timescale 1ns/1ps
module isc_pacer #(
   parameter int TICK_W = 12,
   parameter int COUNT_W = 24
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic run,
   input wire logic sensor_tick,
   input wire logic [TICK_W-1:0] ticks_per_conv,
   output logic done,
   output logic [COUNT_W-1:0] cycles
);

   logic [TICK_W-1:0] tick_count;
   logic [COUNT_W-1:0] clock_count;
   wire last_tick = sensor_tick && (tick_count == ticks_per_conv - 1'b1);
   wire count_full = &clock_count;

   // Reference clocks counted over a fixed number of sensor cycles
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tick_count <= '0;
         clock_count <= '0;
         done <= 1'b0;
         cycles <= '0;
      end else if (!run) begin
         tick_count <= '0;
         clock_count <= '0;
         done <= 1'b0;
      end else begin
         done <= last_tick;
         if (last_tick) begin
            cycles <= clock_count;
            tick_count <= '0;
            // The closing edge is already the first cycle of the next window
            clock_count <= COUNT_W'(1);
         end else begin
            if (sensor_tick) begin
               tick_count <= tick_count + 1'b1;
            end
            if (!count_full) begin
               clock_count <= clock_count + 1'b1;
            end
         end
      end
   end

endmodule : isc_pacer

// ===== rtl/isc_pkg.sv
package isc_pkg;

   // Register offsets
   localparam logic [7:0] ADDR_WATCHDOG = 8'h03;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_THRESH_HIGH = 8'h07;
   localparam logic [7:0] ADDR_THRESH_LOW = 8'h09;
   localparam logic [7:0] ADDR_INT_FUNC = 8'h0A;
   localparam logic [7:0] ADDR_POWER = 8'h0B;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_PROXIMITY = 8'h22;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'h23;
   localparam logic [7:0] ADDR_COUNT_MID = 8'h24;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h25;
   // Range locked while active
   localparam logic [7:0] ADDR_LOCK_FIRST = 8'h01;
   localparam logic [7:0] ADDR_LOCK_LAST = 8'h05;

   // Reset values
   localparam logic [7:0] RST_WATCHDOG = 8'h45;
   localparam logic [7:0] RST_CONFIG = 8'h1B;
   localparam logic [7:0] RST_THRESH_HIGH = 8'hFF;
   localparam logic [7:0] RST_THRESH_LOW = 8'h00;
   localparam logic [7:0] RST_INT_FUNC = 8'h00;
   localparam logic [7:0] RST_POWER = 8'h00;
   localparam logic [7:0] RST_UNMAPPED = 8'h00;

   // Writable bit masks
   localparam logic [7:0] MASK_CONFIG = 8'h1F;
   localparam logic [7:0] MASK_INT_FUNC = 8'h07;
   localparam logic [7:0] MASK_POWER = 8'h01;

   // Field positions
   localparam int AMP_LSB = 3;
   localparam int RESP_LSB = 0;
   localparam int POWER_BIT = 0;
   localparam int STAT_OSC_BIT = 7;
   localparam int STAT_READY_BIT = 6;
   localparam int STAT_WAKE_BIT = 5;
   localparam int STAT_COMP_BIT = 4;

   // Response-time divisor applied to the sensor cycle count
   localparam int RESP_DIVISOR = 3;

   typedef enum logic [2:0] {
      ISC_INT_OFF = 3'h0,
      ISC_INT_WAKE = 3'h1,
      ISC_INT_COMP = 3'h2,
      ISC_INT_READY = 3'h4
   } isc_int_func_t;

   typedef struct packed {
      logic [7:0] proximity;
      logic [23:0] freq_count;
   } isc_result_t;

   // Response-time count in sensor cycles for a code; a conversion takes a third of it
   function automatic logic [12:0] isc_resp_count(input logic [2:0] code);
      logic [12:0] count;
      count = 13'h00C0;
      case (code)
         3'h2: count = 13'h00C0;
         3'h3: count = 13'h0180;
         3'h4: count = 13'h0300;
         3'h5: count = 13'h0600;
         3'h6: count = 13'h0C00;
         3'h7: count = 13'h1800;
         default: count = 13'h00C0;
      endcase
      return count;
   endfunction : isc_resp_count

endpackage : isc_pkg

// ===== rtl/isc_regs.sv
// Summary of operation
// - The watchdog code N is held in its own register and sent to the oscillator watchdog.
// - Config bits 4:3 pick the oscillation amplitude, 1 V, 2 V or 4 V, code 11 reserved.
// - Config bits 2:0 pick the response time 192 to 6144, codes 000 and 001 reserved.
// - Upper threshold resets to all ones, lower to zero, both writable and compared to the result.
// - The interrupt pin shows nothing, wake-up, comparator or active-low ready per a 3-bit code.
// - Power bit 0 clear means standby, set means active with conversions, reset is standby.
// - Status bit 7 reads one when the oscillator has overloaded and stopped.
// - Status bit 6 reads zero when a fresh result waits and one otherwise.
// - Status bit 5 drops to zero on a wake-up above the upper threshold and reads one when disabled.
// - Status bit 4 sets below the lower threshold, clears above the upper, bits 3:0 mean nothing.
// - The 8-bit proximity result reads at offset 0x22.
// - The 24-bit frequency count reads low, middle, high at 0x23, 0x24, 0x25.
// - Count registers 0x23 to 0x25 refresh only when the host reads offset 0x22.
// - Offsets 0x01 to 0x05 ignore writes while the power bit is set.
// - A result is made every response-time count divided by three sensor cycles.
`timescale 1ns/1ps
module isc_regs #(
   parameter int COUNT_W = 24,
   parameter int TICK_W = 12
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic sensor_tick,
   input wire logic [7:0] sensor_proximity,
   input wire logic osc_overload,
   output logic [7:0] watchdog_code,
   output logic [1:0] amplitude_code,
   output logic [12:0] response_count,
   output logic power_mode_select,
   output logic interrupt_pin_n
);

   logic [7:0] sensor_watchdog_setting;
   logic [7:0] converter_configuration;
   logic [7:0] comparator_upper_threshold;
   logic [7:0] comparator_lower_threshold;
   logic [7:0] interrupt_pin_function;
   logic [7:0] power_control;
   logic oscillator_dead_flag;
   logic result_ready_n;
   isc_pkg::isc_result_t latest;
   isc_pkg::isc_result_t snapshot;

   wire conv_done;
   wire [COUNT_W-1:0] conv_cycles;
   wire comp_flag;
   wire wake_n;

   // Decode
   wire active = power_control[isc_pkg::POWER_BIT];
   wire locked = active && (reg_addr >= isc_pkg::ADDR_LOCK_FIRST)
      && (reg_addr <= isc_pkg::ADDR_LOCK_LAST);
   wire write_ok = reg_write && !locked;
   wire wr_watchdog = write_ok && (reg_addr == isc_pkg::ADDR_WATCHDOG);
   wire wr_config = write_ok && (reg_addr == isc_pkg::ADDR_CONFIG);
   wire wr_high = write_ok && (reg_addr == isc_pkg::ADDR_THRESH_HIGH);
   wire wr_low = write_ok && (reg_addr == isc_pkg::ADDR_THRESH_LOW);
   wire wr_int = write_ok && (reg_addr == isc_pkg::ADDR_INT_FUNC);
   wire wr_power = write_ok && (reg_addr == isc_pkg::ADDR_POWER);
   wire rd_proximity = reg_read && (reg_addr == isc_pkg::ADDR_PROXIMITY);

   // Fields
   wire [2:0] resp_code = converter_configuration[isc_pkg::RESP_LSB +: 3];
   wire [1:0] amp_code = converter_configuration[isc_pkg::AMP_LSB +: 2];
   wire [12:0] resp_cycles = isc_pkg::isc_resp_count(resp_code);
   wire [12:0] resp_third = resp_cycles / 13'(isc_pkg::RESP_DIVISOR);
   wire [TICK_W-1:0] ticks_per_conv = resp_third[TICK_W-1:0];
   wire [2:0] int_func = interrupt_pin_function[2:0];
   wire wake_enable = (int_func == 3'(isc_pkg::ISC_INT_WAKE));

   // Conversion result as it stands after this cycle
   isc_pkg::isc_result_t fresh;
   assign fresh.proximity = sensor_proximity;
   assign fresh.freq_count = conv_cycles;

   // Status byte, low nibble zero
   wire [7:0] status_byte = {oscillator_dead_flag, result_ready_n,
      wake_n, comp_flag, 4'h0};

   // Read data mux; a read of 0x22 returns the newest result at once
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = isc_pkg::RST_UNMAPPED;
      case (reg_addr)
         isc_pkg::ADDR_WATCHDOG: next_rdata = sensor_watchdog_setting;
         isc_pkg::ADDR_CONFIG: next_rdata = converter_configuration;
         isc_pkg::ADDR_THRESH_HIGH: next_rdata = comparator_upper_threshold;
         isc_pkg::ADDR_THRESH_LOW: next_rdata = comparator_lower_threshold;
         isc_pkg::ADDR_INT_FUNC: next_rdata = interrupt_pin_function;
         isc_pkg::ADDR_POWER: next_rdata = power_control;
         isc_pkg::ADDR_STATUS: next_rdata = status_byte;
         isc_pkg::ADDR_PROXIMITY: next_rdata = latest.proximity;
         isc_pkg::ADDR_COUNT_LOW: next_rdata = snapshot.freq_count[7:0];
         isc_pkg::ADDR_COUNT_MID: next_rdata = snapshot.freq_count[15:8];
         isc_pkg::ADDR_COUNT_HIGH: next_rdata = snapshot.freq_count[23:16];
         default: next_rdata = isc_pkg::RST_UNMAPPED;
      endcase
   end

   // Interrupt pin function
   logic next_int_n;
   always_comb begin
      next_int_n = 1'b1;
      case (int_func)
         3'(isc_pkg::ISC_INT_WAKE): next_int_n = wake_n;
         3'(isc_pkg::ISC_INT_COMP): next_int_n = ~comp_flag;
         3'(isc_pkg::ISC_INT_READY): next_int_n = result_ready_n;
         default: next_int_n = 1'b1;
      endcase
   end

   // Configuration registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sensor_watchdog_setting <= isc_pkg::RST_WATCHDOG;
         converter_configuration <= isc_pkg::RST_CONFIG;
      end else begin
         if (wr_watchdog) begin
            sensor_watchdog_setting <= reg_wdata;
         end
         if (wr_config) begin
            converter_configuration <= reg_wdata & isc_pkg::MASK_CONFIG;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         comparator_upper_threshold <= isc_pkg::RST_THRESH_HIGH;
         comparator_lower_threshold <= isc_pkg::RST_THRESH_LOW;
      end else begin
         if (wr_high) begin
            comparator_upper_threshold <= reg_wdata;
         end
         if (wr_low) begin
            comparator_lower_threshold <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         interrupt_pin_function <= isc_pkg::RST_INT_FUNC;
         power_control <= isc_pkg::RST_POWER;
      end else begin
         if (wr_int) begin
            interrupt_pin_function <= reg_wdata & isc_pkg::MASK_INT_FUNC;
         end
         if (wr_power) begin
            power_control <= reg_wdata & isc_pkg::MASK_POWER;
         end
      end
   end

   // Newest result from the pacer
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         latest <= '0;
      end else if (conv_done) begin
         latest <= fresh;
      end
   end

   // Snapshot taken when the host starts a proximity read
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         snapshot <= '0;
      end else if (rd_proximity) begin
         snapshot <= latest;
      end
   end

   // Ready flag: a new conversion wins over a read in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         result_ready_n <= 1'b1;
      end else if (conv_done) begin
         result_ready_n <= 1'b0;
      end else if (rd_proximity || !active) begin
         result_ready_n <= 1'b1;
      end
   end

   // Outputs
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         oscillator_dead_flag <= 1'b0;
         reg_rdata <= isc_pkg::RST_UNMAPPED;
         interrupt_pin_n <= 1'b1;
      end else begin
         oscillator_dead_flag <= osc_overload;
         reg_rdata <= next_rdata;
         interrupt_pin_n <= next_int_n;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         watchdog_code <= isc_pkg::RST_WATCHDOG;
         amplitude_code <= isc_pkg::RST_CONFIG[isc_pkg::AMP_LSB +: 2];
         response_count <= '0;
         power_mode_select <= 1'b0;
      end else begin
         watchdog_code <= sensor_watchdog_setting;
         amplitude_code <= amp_code;
         response_count <= resp_cycles;
         power_mode_select <= active;
      end
   end

   isc_pacer #(
      .TICK_W(TICK_W),
      .COUNT_W(COUNT_W)
   ) u_pacer (
      .clock(clock),
      .rstn(rstn),
      .run(active),
      .sensor_tick(sensor_tick),
      .ticks_per_conv(ticks_per_conv),
      .done(conv_done),
      .cycles(conv_cycles)
   );

   isc_hyst #(
      .DATA_W(8)
   ) u_hyst (
      .clock(clock),
      .rstn(rstn),
      .update(conv_done),
      .value(sensor_proximity),
      .high(comparator_upper_threshold),
      .low(comparator_lower_threshold),
      .wake_enable(wake_enable),
      .comp_flag(comp_flag),
      .wake_n(wake_n)
   );

endmodule : isc_regs

// ===== sim/isc_regs_chk.sv
`timescale 1ns/1ps
module isc_regs_chk #(
   parameter int COUNT_W = 24,
   parameter int TICK_W = 12
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic sensor_tick,
   input wire logic [7:0] sensor_proximity,
   input wire logic osc_overload,
   input wire logic [7:0] watchdog_code,
   input wire logic [1:0] amplitude_code,
   input wire logic [12:0] response_count,
   input wire logic power_mode_select,
   input wire logic interrupt_pin_n
);
   logic [2:0] mode;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // Mirror of the interrupt function field
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode <= 3'h0;
      end else if (reg_write && reg_addr == isc_pkg::ADDR_INT_FUNC) begin
         mode <= reg_wdata[2:0];
      end
   end
   a_unmapped_zero: assert property (
      reg_addr > 8'h25 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_status_low: assert property (
      reg_addr == isc_pkg::ADDR_STATUS |=> reg_rdata[3:0] == 4'h0)
      else $error("status low bits not zero");
   a_osc_dead: assert property (
      osc_overload && $past(osc_overload) && $past(osc_overload, 2)
      && reg_addr == isc_pkg::ADDR_STATUS |=> reg_rdata[7])
      else $error("overload not reported");
   // Outputs trail the register by one more edge than the write
   a_locked_cfg: assert property (
      power_mode_select && !$past(reg_write) && reg_write
      && reg_addr inside {8'h03, 8'h04}
      |=> ##1 $stable(watchdog_code) && $stable(amplitude_code))
      else $error("locked register changed");
   a_watchdog_wr: assert property (
      !power_mode_select && !$past(reg_write) && reg_write
      && reg_addr == isc_pkg::ADDR_WATCHDOG
      |=> ##1 watchdog_code == $past(reg_wdata, 2))
      else $error("watchdog code not taken");
   a_amp_wr: assert property (
      !power_mode_select && !$past(reg_write) && reg_write
      && reg_addr == isc_pkg::ADDR_CONFIG
      |=> ##1 amplitude_code == $past(reg_wdata[4:3], 2))
      else $error("amplitude not taken");
   a_thresh_back: assert property (
      reg_write && reg_addr == isc_pkg::ADDR_THRESH_HIGH ##1
      !reg_write && reg_addr == isc_pkg::ADDR_THRESH_HIGH
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("threshold readback wrong");
   a_power_wr: assert property (
      reg_write && reg_addr == isc_pkg::ADDR_POWER
      |=> ##1 power_mode_select == $past(reg_wdata[0], 2))
      else $error("power bit not taken");
   a_pin_off: assert property (
      mode == 3'h0 && $past(mode) == 3'h0 |-> interrupt_pin_n)
      else $error("pin active while off");
   c_prox_read: cover property (reg_read && reg_addr == 8'h22);
   c_locked_wr: cover property (power_mode_select && reg_write);
   c_pin_low: cover property ($fell(interrupt_pin_n));
endmodule : isc_regs_chk

bind isc_regs isc_regs_chk #(.COUNT_W(COUNT_W), .TICK_W(TICK_W)) u_chk (
   .clock(clock), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .sensor_tick(sensor_tick),
   .sensor_proximity(sensor_proximity), .osc_overload(osc_overload),
   .watchdog_code(watchdog_code), .amplitude_code(amplitude_code),
   .response_count(response_count), .power_mode_select(power_mode_select),
   .interrupt_pin_n(interrupt_pin_n));

// ===== sim/isc_sensor_model.sv
`timescale 1ns/1ps
module isc_sensor_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [3:0] period,
   input wire logic [7:0] level,
   input wire logic stall,
   output logic sensor_tick,
   output logic [7:0] sensor_proximity,
   output logic osc_overload
);
   logic [3:0] cnt;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 4'h0;
      end else if (cnt >= period - 4'h1) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // A stopped oscillator gives no ticks and raises the overload level
   assign sensor_tick = (cnt == 4'h0) && !stall && rstn;
   assign osc_overload = stall;
   assign sensor_proximity = level;
endmodule : isc_sensor_model

// ===== sim/test_inductive_sensor_config_status_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
   $display("Error %0t: got %h exp %h", $time, a, e); end end
module test_inductive_sensor_config_status_regs;
   logic clock, rstn, reg_write, reg_read, stall, osc, tick, pin_n, pwr;
   logic [7:0] addr, wdata, rdata, level, prox, wd;
   logic [3:0] period;
   logic [1:0] amp;
   logic [12:0] resp;
   int error_cnt, compares, cyc;
   logic [7:0] ra [6] = '{8'h03, 8'h04, 8'h07, 8'h09, 8'h0A, 8'h0B};
   logic [7:0] rv [6] = '{8'h45, 8'h1B, 8'hFF, 8'h00, 8'h00, 8'h00};
   logic [7:0] sm [5] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h00};
   logic [7:0] sl [5] = '{8'h10, 8'h50, 8'h90, 8'h90, 8'h10};
   logic [7:0] ss [5] = '{8'h30, 8'h30, 8'h20, 8'h00, 8'h30};
   logic sp [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   isc_regs u_dut (.clock(clock), .rstn(rstn), .reg_addr(addr),
      .reg_wdata(wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(rdata), .sensor_tick(tick), .sensor_proximity(prox),
      .osc_overload(osc), .watchdog_code(wd), .amplitude_code(amp),
      .response_count(resp), .power_mode_select(pwr),
      .interrupt_pin_n(pin_n));
   isc_sensor_model u_sens (.clock(clock), .rstn(rstn), .period(period),
      .level(level), .stall(stall), .sensor_tick(tick),
      .sensor_proximity(prox), .osc_overload(osc));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic end_sim();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("Error %0t: timeout", $time);
         end_sim();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clock);
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      addr = a;
      wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      `CHK(rdata, e)
   endtask : rd
   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      period = 4'h4;
      level = 8'h40;
      stall = 1'b0;
      wt(3);
      rstn = 1'b1;
      foreach (ra[i]) rd(ra[i], rv[i]);
      rd(8'h20, 8'h60);
      rd(8'h30, 8'h00);
      `CHK({wd, amp, resp, pwr, pin_n}, {8'h45, 2'h3, 13'h0180, 2'h1})
      $display("test reset done");
      for (int c = 2; c < 8; c++) begin
         wr(8'h04, {3'h0, 2'h2, c[2:0]});
         wt(2);
         `CHK({amp, resp}, {2'h2, 13'h00C0 << (c - 2)})
      end
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h1F);
      wr(8'h0A, 8'hFF);
      rd(8'h0A, 8'h07);
      wr(8'h0B, 8'hFE);
      rd(8'h0B, 8'h00);
      wr(8'h03, 8'h9A);
      rd(8'h03, 8'h9A);
      `CHK(wd, 8'h9A)
      $display("test fields done");
      wr(8'h04, 8'h02);
      wr(8'h0A, 8'h04);
      wr(8'h0B, 8'h01);
      wr(8'h03, 8'h11);
      wr(8'h04, 8'h1F);
      rd(8'h03, 8'h9A);
      rd(8'h04, 8'h02);
      `CHK(pwr, 1'b1)
      for (int i = 0; i < 600 && pin_n !== 1'b0; i++)
         @(negedge clock);
      `CHK(pin_n, 1'b0)
      wt(300);
      rd(8'h20, 8'h20);
      rd(8'h22, 8'h40);
      rd(8'h20, 8'h60);
      rd(8'h23, 8'h00);
      rd(8'h24, 8'h01);
      rd(8'h25, 8'h00);
      $display("test convert done");
      period = 4'h2;
      level = 8'h10;
      wt(600);
      rd(8'h24, 8'h01);
      rd(8'h23, 8'h00);
      rd(8'h22, 8'h10);
      rd(8'h23, 8'h80);
      rd(8'h24, 8'h00);
      $display("test freeze done");
      wr(8'h07, 8'h80);
      wr(8'h09, 8'h20);
      rd(8'h07, 8'h80);
      foreach (sm[i]) begin
         wr(8'h0A, sm[i]);
         level = sl[i];
         wt(300);
         rd(8'h20, ss[i]);
         `CHK(pin_n, sp[i])
      end
      $display("test compare done");
      stall = 1'b1;
      wt(5);
      rd(8'h20, 8'hB0);
      stall = 1'b0;
      wr(8'h0B, 8'h00);
      wt(3);
      rd(8'h20, 8'h70);
      wr(8'h03, 8'h11);
      rd(8'h03, 8'h11);
      $display("test standby done");
      end_sim();
   end
endmodule : test_inductive_sensor_config_status_regs
